// *** logic/spp_defs.svh ***
// constants for the serial peripheral port: widths and counts, reset values, timing
// assumes it is included by bare name from logic/ files; definitions only
`ifndef SPP_DEFS_SVH
`define SPP_DEFS_SVH

`define SPP_BITS_PER_BYTE 4'h8
`define SPP_CNT_W 7
`define SPP_CLK_NS 25
`define SPP_DATA_RST 8'h00
`define SPP_CTRL_RST 8'h00
`define SPP_SLV_CLK_RATIO 4
`define SPP_SYNC_STAGES 2

`endif

// *** logic/spp_pkg.sv ***
// types for the serial peripheral port
// assumes spp_defs.svh is compiled alongside
package spp_pkg;

    // control settings written by software
    typedef struct packed {
        logic transfer_irq_enable;
        logic port_enable_bit;
        logic bit_order_select;
        logic master_select_bit;
        logic clock_polarity_bit;
        logic clock_phase_bit;
        logic rate_select_high;
        logic rate_select_low;
    } spp_ctrl_s;

    // pin directions driven out of the block
    typedef struct packed {
        logic mosi_oe;
        logic miso_oe;
        logic sck_oe;
        logic ss_oe;
    } spp_pins_s;

    // gray-coded transfer states
    typedef enum logic [1:0] {
        SPP_IDLE = 2'b00,
        SPP_LEAD = 2'b01,
        SPP_TRAIL = 2'b11
    } spp_state_e;

endpackage

// *** logic/spp_sync.sv ***
// two-stage synchroniser for a level
// assumes the input may change at any time relative to i_core_clk
`timescale 1ns/1ps
`default_nettype none
module spp_sync
    import spp_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_d,
    output logic o_q
);
    logic meta_ff; // first stage, read only by the second
    logic sync_ff;

    // two flops in series
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= i_d;
            sync_ff <= meta_ff;
        end
    end
    assign o_q = sync_ff;
endmodule
`default_nettype wire

// *** logic/spp_rate.sv ***
// master serial clock divider: pulses one half-period tick
// assumes i_run clears the count between bytes
`timescale 1ns/1ps
`default_nettype none
`include "spp_defs.svh"
module spp_rate
    import spp_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic i_dbl,
    input wire logic [1:0] i_sel,
    output logic o_tick
);
    logic [`SPP_CNT_W-1:0] cnt_ff; // half-period counter
    logic [`SPP_CNT_W-1:0] half; // half period minus one

    // divide by 4,16,64,128 or with double speed 2,8,32,64
    always_comb begin
        unique case ({i_dbl, i_sel})
            3'h0: half = 7'h01;
            3'h1: half = 7'h07;
            3'h2: half = 7'h1F;
            3'h3: half = 7'h3F;
            3'h4: half = 7'h00;
            3'h5: half = 7'h03;
            3'h6: half = 7'h0F;
            3'h7: half = 7'h1F;
        endcase
    end

    // count to the half period, then wrap
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !i_run || o_tick) begin
            cnt_ff <= 7'h00;
        end else begin
            cnt_ff <= cnt_ff + 7'h01;
        end
    end
    assign o_tick = i_run && (cnt_ff == half);
endmodule
`default_nettype wire

// *** logic/spp_core.sv ***
// serial peripheral port core: master/slave byte shifter with plain control ports
// assumes software strobes are one-cycle pulses; slave pins are sampled through synchronisers
`timescale 1ns/1ps
`default_nettype none
`include "spp_defs.svh"
module spp_core
    import spp_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_power_reduce_serial_bit, // high holds the port off
    input wire logic i_ctrl_wr, // load control settings
    input wire spp_ctrl_s i_ctrl,
    input wire logic i_double_rate_bit,
    input wire logic i_data_wr, // shift data register write
    input wire logic [7:0] i_data,
    input wire logic i_data_rd, // shift data register read
    input wire logic i_status_rd, // status register read
    input wire logic i_vector_ack, // interrupt vector taken
    input wire logic i_ss_is_input, // select pin configured as input
    input wire logic i_mosi,
    input wire logic i_miso,
    input wire logic i_sck,
    input wire logic i_ss_n,
    output logic o_mosi,
    output logic o_sck,
    output logic o_miso,
    output spp_pins_s o_force_in, // high: pin forced to input
    output logic o_miso_oe_allow, // low: miso released
    output logic [7:0] o_rx_data,
    output logic o_transfer_done_flag,
    output logic o_write_collision_flag,
    output logic o_master_select_bit,
    output logic o_irq,
    output logic o_busy
);
    spp_ctrl_s ctrl_ff; // software settings
    logic dbl_ff;
    spp_state_e state_ff;
    logic [7:0] shift_ff; // single transmit/receive shifter
    logic [3:0] bits_ff; // bits sampled this byte
    logic [7:0] rx_ff; // receive buffer
    logic done_ff, write_collision_flag_ff, armed_ff;
    logic mosi_ff, sck_ff, miso_ff, irq_ff;
    spp_pins_s force_ff;
    logic miso_en_ff;
    logic sck_s, ss_s, mosi_s, sck_d_ff;
    logic tick;

    wire logic on = ctrl_ff.port_enable_bit && !i_power_reduce_serial_bit;
    wire logic mst = on && ctrl_ff.master_select_bit;
    wire logic slv = on && !ctrl_ff.master_select_bit;
    wire logic busy = (state_ff != SPP_IDLE);
    wire logic sel_lost = mst && i_ss_is_input && !ss_s;
    // slave edges from the synchronised clock; leading edge leaves idle level
    wire logic s_lead = slv && !ss_s && (sck_s != sck_d_ff) && (sck_s != ctrl_ff.clock_polarity_bit);
    wire logic s_trail = slv && !ss_s && (sck_s != sck_d_ff) && (sck_s == ctrl_ff.clock_polarity_bit);
    wire logic m_lead = mst && (state_ff == SPP_LEAD) && tick;
    wire logic m_trail = mst && (state_ff == SPP_TRAIL) && tick;
    wire logic lead = m_lead || s_lead;
    wire logic trail = m_trail || s_trail;
    wire logic sample = ctrl_ff.clock_phase_bit ? trail : lead;
    wire logic setup = ctrl_ff.clock_phase_bit ? lead : trail;
    wire logic rx_bit = mst ? i_miso : mosi_s;
    wire logic byte_end = sample && (bits_ff == `SPP_BITS_PER_BYTE - 4'h1);
    // last edge of a master byte: phase 0 ends on the trailing edge after the eighth sample
    wire logic m_stop = m_trail && (ctrl_ff.clock_phase_bit ? byte_end : (bits_ff == 4'h0));
    // done sources; a master only reports once its clock has stopped
    wire logic done_set = m_stop || (byte_end && slv && !ss_s) || sel_lost;
    wire logic [7:0] shifted = ctrl_ff.bit_order_select ? {rx_bit, shift_ff[7:1]} : {shift_ff[6:0], rx_bit};
    wire logic tx_bit = ctrl_ff.bit_order_select ? shift_ff[0] : shift_ff[7];

    // pins sampled into the core clock domain; external clock limit
    spp_sync #(.RST_VAL(1'b0)) u_sck (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_d(i_sck), .o_q(sck_s));
    spp_sync #(.RST_VAL(1'b1)) u_ss (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_d(i_ss_n), .o_q(ss_s));
    spp_sync #(.RST_VAL(1'b0)) u_mosi (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_d(i_mosi), .o_q(mosi_s));

    // master rate generator
    spp_rate u_rate (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_run(mst && busy),
        .i_dbl(dbl_ff),
        .i_sel({ctrl_ff.rate_select_high, ctrl_ff.rate_select_low}),
        .o_tick(tick)
    );

    // control settings; external select demotes master
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl_ff <= `SPP_CTRL_RST;
            dbl_ff <= 1'b0;
        end else begin
            if (i_ctrl_wr) begin
                ctrl_ff <= i_ctrl;
                dbl_ff <= i_double_rate_bit;
            end
            if (sel_lost) begin
                ctrl_ff.master_select_bit <= 1'b0;
            end
        end
    end

    // delayed synchronised clock for edge detection
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sck_d_ff <= 1'b0;
        end else begin
            sck_d_ff <= sck_s;
        end
    end

    // transfer state and shifter
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !on || sel_lost) begin
            state_ff <= SPP_IDLE;
            bits_ff <= 4'h0;
            if (i_rst) begin
                shift_ff <= `SPP_DATA_RST;
            end
        end else if (slv && ss_s) begin
            // unselected slave drops partial bytes but accepts a load
            state_ff <= SPP_IDLE;
            bits_ff <= 4'h0;
            if (i_data_wr) begin
                shift_ff <= i_data;
            end
        end else if (i_data_wr && !busy && (mst || bits_ff == 4'h0)) begin
            shift_ff <= i_data;
            state_ff <= mst ? SPP_LEAD : SPP_IDLE;
        end else begin
            if (mst && busy && tick) begin
                state_ff <= (state_ff == SPP_LEAD) ? SPP_TRAIL : SPP_LEAD;
            end
            if (sample) begin
                shift_ff <= shifted;
                bits_ff <= byte_end ? 4'h0 : bits_ff + 4'h1;
            end
            if (m_stop) begin
                state_ff <= SPP_IDLE;
            end
        end
    end

    // serial outputs: data set up on the shifting edge, idle clock level
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            mosi_ff <= 1'b0;
            miso_ff <= 1'b0;
            sck_ff <= 1'b0;
        end else begin
            sck_ff <= ctrl_ff.clock_polarity_bit ^ (mst && state_ff == SPP_LEAD && busy && !(m_lead)) ^ m_lead;
            if (mst && i_data_wr && !busy) begin
                // phase 0 samples on the first edge, so the first bit must already stand
                mosi_ff <= ctrl_ff.bit_order_select ? i_data[0] : i_data[7];
            end else if (!busy || setup) begin
                mosi_ff <= tx_bit;
            end
            if ((slv && bits_ff == 4'h0 && !s_trail) || setup) begin
                miso_ff <= tx_bit;
            end
        end
    end

    // receive buffer, overwritten by each completed byte
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rx_ff <= `SPP_DATA_RST;
        end else if (byte_end && on) begin
            rx_ff <= shifted;
        end
    end

    // done flag, collision flag, status-then-data clear; set wins
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            done_ff <= 1'b0;
            write_collision_flag_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else begin
            if (i_status_rd) begin
                armed_ff <= done_ff || write_collision_flag_ff;
            end else if (i_data_rd || i_data_wr) begin
                armed_ff <= 1'b0;
            end
            done_ff <= done_set ||
                       (done_ff && !i_vector_ack && !(armed_ff && (i_data_rd || i_data_wr)));
            write_collision_flag_ff <= (i_data_wr && on && (busy || bits_ff != 4'h0)) ||
                       (write_collision_flag_ff && !(armed_ff && (i_data_rd || i_data_wr)));
        end
    end

    // pin overrides and interrupt request
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            force_ff <= 4'h0;
            miso_en_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            force_ff.miso_oe <= mst;
            force_ff.mosi_oe <= slv;
            force_ff.sck_oe <= slv;
            force_ff.ss_oe <= slv;
            miso_en_ff <= slv && !ss_s;
            irq_ff <= ctrl_ff.transfer_irq_enable && done_ff;
        end
    end

    assign o_mosi = mosi_ff;
    assign o_sck = sck_ff;
    assign o_miso = miso_ff;
    assign o_force_in = force_ff;
    assign o_miso_oe_allow = miso_en_ff;
    assign o_rx_data = rx_ff;
    assign o_transfer_done_flag = done_ff;
    assign o_write_collision_flag = write_collision_flag_ff;
    assign o_master_select_bit = ctrl_ff.master_select_bit;
    assign o_irq = irq_ff;
    assign o_busy = state_ff[0]; // lead and trail codes both carry bit 0, idle does not

    property p_start;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_data_wr && mst && !busy && !sel_lost && !i_ctrl_wr) |=> busy;
    endproperty
    a_start: assert property (p_start) else $error("write did not start master byte");

    property p_done;
        @(posedge i_core_clk) disable iff (i_rst)
        done_set |=> o_transfer_done_flag;
    endproperty
    a_done: assert property (p_done) else $error("byte end did not set done");

    property p_write_collision_flag;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_data_wr && mst && busy) |=> o_write_collision_flag;
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

    property p_demote;
        @(posedge i_core_clk) disable iff (i_rst)
        sel_lost |=> (!o_master_select_bit && o_transfer_done_flag);
    endproperty
    a_demote: assert property (p_demote) else $error("select low did not demote master");

    property p_off;
        @(posedge i_core_clk) disable iff (i_rst)
        !on |=> (!o_busy && o_force_in == 4'h0);
    endproperty
    a_off: assert property (p_off) else $error("disabled port active");

    property p_miso_rel;
        @(posedge i_core_clk) disable iff (i_rst)
        (slv && ss_s) |=> !o_miso_oe_allow;
    endproperty
    a_miso_rel: assert property (p_miso_rel) else $error("miso not released");

    property p_rx_hold;
        @(posedge i_core_clk) disable iff (i_rst)
        !(byte_end && on) |=> $stable(o_rx_data);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("receive buffer changed");

    property p_vec;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_vector_ack && !done_set) |=> !o_transfer_done_flag;
    endproperty
    a_vec: assert property (p_vec) else $error("vector did not clear done");

    // the final clock edge of a master byte
    sequence s_master_last;
        m_stop;
    endsequence

    property p_stop;
        @(posedge i_core_clk) disable iff (i_rst)
        s_master_last |=> (!o_busy && o_transfer_done_flag);
    endproperty
    a_stop: assert property (p_stop) else $error("master clock did not stop with done");

    property p_irq;
        @(posedge i_core_clk) disable iff (i_rst)
        (ctrl_ff.transfer_irq_enable && o_transfer_done_flag) |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not requested");

    property p_force_mst;
        @(posedge i_core_clk) disable iff (i_rst)
        mst |=> (o_force_in == 4'b0100);
    endproperty
    a_force_mst: assert property (p_force_mst) else $error("master pin overrides wrong");

    property p_force_slv;
        @(posedge i_core_clk) disable iff (i_rst)
        slv |=> (o_force_in == 4'b1011);
    endproperty
    a_force_slv: assert property (p_force_slv) else $error("slave pin overrides wrong");
endmodule
`default_nettype wire

// *** bench/spp_far_slave.sv ***
// behavioural far-side slave used while the port runs as master
// assumes the bench frames each packet on i_ss_n and mirrors the port's mode bits
`timescale 1ns/1ps
`default_nettype none
module spp_far_slave (
    input wire logic i_sck,
    input wire logic i_mosi,
    input wire logic i_ss_n,
    input wire logic i_clock_polarity_bit,
    input wire logic i_clock_phase_bit,
    input wire logic i_lsb,
    input wire logic [7:0] i_tx,
    output logic o_miso,
    output logic [7:0] o_rx
);
    int k = 0; // index of the bit on the line
    logic drv = 1'b0; // bit presented while selected
    // bit of the reply byte in the chosen order
    function automatic logic pick(input int n);
        return i_lsb ? i_tx[n] : i_tx[7 - n];
    endfunction
    // released line flips, so a stale copy can never be mistaken for data
    assign o_miso = i_ss_n ? ~drv : drv;
    // frame start: phase 0 needs the first bit before the first edge
    always @(negedge i_ss_n) begin
        k = 0;
        o_rx = 8'h00;
        if (!i_clock_phase_bit) drv = pick(0);
    end
    // sample on one edge, set up on the other
    always @(i_sck) begin
        if (!i_ss_n) begin
            if ((i_sck != i_clock_polarity_bit) ^ i_clock_phase_bit) o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
            else begin
                if (!i_clock_phase_bit) k = k + 1;
                if (k < 8) drv = pick(k);
                if (i_clock_phase_bit) k = k + 1;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/serial_peripheral_port_bench.sv ***
// self-checking bench for spp_core with a far-side slave model
// assumes a 40 MHz clock; the bench plays software and, in slave runs, the external master
`timescale 1ns/1ps
`default_nettype none
module serial_peripheral_port_bench import spp_pkg::*;;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic pr = 1'b0, ctrl_wr = 1'b0, dbl = 1'b0, data_wr = 1'b0, data_rd = 1'b0;
    logic status_rd = 1'b0, vec = 1'b0, ss_in = 1'b0, tb_mosi = 1'b0, tb_sck = 1'b0, ss_n = 1'b1;
    spp_ctrl_s ctrl = '0;
    logic [7:0] data = 8'h00, far_tx = 8'h00, rx, far_rx;
    logic o_mosi, o_sck, o_miso, miso_ok, done, coll, mst, irq, busy, far_miso;
    spp_pins_s force_in;
    int errors = 0;
    int samples_checked = 0;
    spp_core i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_power_reduce_serial_bit(pr),
        .i_ctrl_wr(ctrl_wr), .i_ctrl(ctrl), .i_double_rate_bit(dbl), .i_data_wr(data_wr), .i_data(data),
        .i_data_rd(data_rd), .i_status_rd(status_rd), .i_vector_ack(vec), .i_ss_is_input(ss_in),
        .i_mosi(tb_mosi), .i_miso(far_miso), .i_sck(tb_sck), .i_ss_n(ss_n), .o_mosi(o_mosi), .o_sck(o_sck),
        .o_miso(o_miso), .o_force_in(force_in), .o_miso_oe_allow(miso_ok), .o_rx_data(rx),
        .o_transfer_done_flag(done), .o_write_collision_flag(coll), .o_master_select_bit(mst),
        .o_irq(irq), .o_busy(busy));
    spp_far_slave i_far (.i_sck(o_sck), .i_mosi(o_mosi), .i_ss_n(ss_n), .i_clock_polarity_bit(ctrl.clock_polarity_bit),
        .i_clock_phase_bit(ctrl.clock_phase_bit), .i_lsb(ctrl.bit_order_select), .i_tx(far_tx), .o_miso(far_miso),
        .o_rx(far_rx));
    // 25 ns period
    initial begin
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    task automatic conclude();
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // compare and report at once
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // ends on a falling edge so outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        @(negedge i_core_clk);
    endtask
    task automatic setup(input spp_ctrl_s c, input logic d);
        @(posedge i_core_clk);
        ctrl <= c;
        dbl <= d;
        ctrl_wr <= 1'b1;
        @(posedge i_core_clk) ctrl_wr <= 1'b0;
        // let sck settle at its new idle level before any select change
        @(posedge i_core_clk);
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge i_core_clk);
        data <= d;
        data_wr <= 1'b1;
        @(posedge i_core_clk) data_wr <= 1'b0;
    endtask
    // clear by vector taken, or by status read followed by data read
    task automatic clr(input logic by_vec);
        @(posedge i_core_clk);
        vec <= by_vec;
        status_rd <= !by_vec;
        @(posedge i_core_clk);
        vec <= 1'b0;
        status_rd <= 1'b0;
        data_rd <= !by_vec;
        @(posedge i_core_clk) data_rd <= 1'b0;
        cyc(2);
        chk("done clear", done, 0);
        chk("collision clear", coll, 0);
        chk("irq clear", irq, 0);
    endtask
    // bounded wait; counts cycles with sck away from its idle level
    task automatic wait_done(input logic pol, output int act);
        act = 0;
        for (int t = 0; t < 3000 && done !== 1'b1; t++) begin
            @(negedge i_core_clk);
            if (o_sck !== pol) act++;
        end
        if (done !== 1'b1) errors++;
    endtask
    // four modes, both bit orders, four divider settings
    task automatic master_rates();
        int divs [4] = '{2, 16, 32, 128};
        int act;
        for (int i = 0; i < 4; i++) begin
            far_tx <= 8'hC3 ^ i[7:0];
            setup(spp_ctrl_s'({i[0], 1'b1, i[0], 1'b1, i[1], i[0], i[1:0]}), ~i[0]);
            @(posedge i_core_clk) ss_n <= 1'b0;
            cyc(2);
            chk("master pin force", force_in, 4'b0100);
            wr(8'h5A + i[7:0]);
            wait_done(i[1], act);
            chk("byte at far side", far_rx, 8'h5A + i[7:0]);
            chk("receive buffer", rx, 8'hC3 ^ i[7:0]);
            chk("active sck cycles", act, 4 * divs[i]);
            chk("done flag", done, 1);
            cyc(1);
            chk("irq", irq, i[0]);
            @(posedge i_core_clk) ss_n <= 1'b1;
            clr(i[0]);
        end
    endtask
    // second write mid byte is refused; next byte follows in the same frame
    task automatic collide();
        int act;
        far_tx <= 8'h96;
        setup(spp_ctrl_s'(8'hD0), 1'b1);
        @(posedge i_core_clk) ss_n <= 1'b0;
        cyc(2);
        wr(8'h81);
        wr(8'h7E);
        cyc(1);
        chk("collision flag", coll, 1);
        chk("still busy", busy, 1);
        wait_done(1'b0, act);
        chk("first byte kept", far_rx, 8'h81);
        chk("first reply", rx, 8'h96);
        clr(1'b0);
        wr(8'h3C);
        wait_done(1'b0, act);
        chk("next byte", far_rx, 8'h3C);
        @(posedge i_core_clk) ss_n <= 1'b1;
        clr(1'b0);
    endtask
    // powered down, then disabled: a write must start nothing
    task automatic stay_idle();
        for (int i = 0; i < 2; i++) begin
            setup(spp_ctrl_s'(i ? 8'h90 : 8'hD0), 1'b1);
            @(posedge i_core_clk) pr <= (i == 0);
            wr(8'hFF);
            cyc(20);
            chk("idle busy", busy, 0);
            chk("idle done", done, 0);
            if (i) chk("disabled pin force", force_in, 4'b0000);
        end
        @(posedge i_core_clk) pr <= 1'b0;
    endtask
    // external select low on an input select pin demotes the master
    task automatic demote();
        setup(spp_ctrl_s'(8'h50), 1'b0);
        @(posedge i_core_clk) ss_in <= 1'b1;
        cyc(3);
        chk("master kept", mst, 1);
        @(posedge i_core_clk) ss_n <= 1'b0;
        cyc(8);
        chk("demoted", mst, 0);
        chk("demote done", done, 1);
        @(posedge i_core_clk);
        ss_n <= 1'b1;
        ss_in <= 1'b0;
        clr(1'b0);
    endtask
    // bench acts as a mode 0 master at a fourteenth of the core clock
    task automatic slave();
        logic [7:0] got;
        logic [7:0] pat;
        pat = 8'h6D;
        setup(spp_ctrl_s'(8'hC0), 1'b0);
        wr(8'hB4);
        repeat (16) begin
            @(posedge i_core_clk) tb_sck <= ~tb_sck;
            cyc(5);
        end
        chk("unselected done", done, 0);
        chk("miso released", miso_ok, 0);
        chk("slave pin force", force_in, 4'b1011);
        @(posedge i_core_clk) ss_n <= 1'b0;
        cyc(6);
        chk("miso allowed", miso_ok, 1);
        for (int b = 7; b >= 0; b--) begin
            @(posedge i_core_clk);
            tb_mosi <= pat[b];
            tb_sck <= 1'b0;
            cyc(6);
            got[b] = o_miso;
            @(posedge i_core_clk) tb_sck <= 1'b1;
            cyc(6);
        end
        @(posedge i_core_clk) tb_sck <= 1'b0;
        cyc(6);
        chk("slave rx", rx, 8'h6D);
        chk("slave tx", got, 8'hB4);
        chk("slave done", done, 1);
        chk("slave irq", irq, 1);
        @(posedge i_core_clk) ss_n <= 1'b1;
        clr(1'b0);
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge i_core_clk);
        i_rst <= 1'b0;
        cyc(3);
        chk("reset done", done, 0);
        chk("reset master", mst, 0);
        master_rates();
        collide();
        stay_idle();
        demote();
        slave();
        conclude();
    end
    // cuts a hang short
    initial begin
        repeat (40000) @(posedge i_core_clk);
        errors++;
        conclude();
    end
endmodule
`default_nettype wire
